// ---- hw/scl_link_slave.sv ----
/*
 Serial computer link slave: start-stop receiver and transmitter,
 frame parser, station and sum check, command decode, coded response
 delay and response generator, with a classic Wishbone register slave.
 Assumes rxd is synchronous to clk_sys and that the line driver is
 enabled by txEn (half duplex, four wire).
*/
`timescale 1ns/100ps
module scl_link_slave
	import scl_pkg::*;
#(
	parameter int DEPTH    = 16,
	parameter int STEP_CYC = STEP_CYC_DEF
)(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        ce,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        rxd,
	output logic             txd,
	output logic             txEn,
	output logic             snSel
);
	localparam int BW = $clog2(DEPTH);

	typedef struct packed {
		logic [31:0]           wbDat;
		logic                  wbAck;
		logic [11:0]           ctrl;
		logic [15:0]           baud;
		scl_rx_e               rxSt;
		logic [15:0]           rxCnt;
		logic [3:0]            rxBit;
		logic [9:0]            rxSh;
		scl_prs_e              pSt;
		logic [23:0]           code;
		logic                  selPres;
		logic [3:0]            selVal;
		logic [3:0]            riCode;
		logic [7:0]            sum;
		logic [7:0]            sc1;
		logic [7:0]            sc0;
		logic [7:0]            cnt;
		logic                  parErr;
		logic [DEPTH-1:0][7:0] buff;
		scl_cmd_e              cmd;
		logic [1:0]            prog;
		logic [1:0]            unit;
		logic [7:0]            len;
		logic                  pend;
		logic                  waitDly;
		logic [5:0]            steps;
		logic [31:0]           cyc;
		logic                  dlyDone;
		logic                  go;
		scl_tx_e               tSt;
		logic [7:0]            tIdx;
		logic [7:0]            tLen;
		logic [7:0]            tSum;
		logic [10:0]           tSh;
		logic [3:0]            tBit;
		logic [15:0]           tCnt;
		logic                  txd;
		logic                  txEn;
		logic                  snSel;
	} scl_st_s;

	localparam scl_st_s ST_RST = '{ctrl: CTRL_RST, baud: BAUD_RST,
		rxSt: RX_IDLE, pSt: P_IDLE, cmd: CMD_NONE, tSt: T_IDLE,
		txd: 1'b1, default: '0};

	logic [1:0] rstPipe_ff;
	logic       rstInt_b;
	scl_st_s    st_ff;
	scl_st_s    nxt_st;

	// ASCII hex digit to value; letters A-F sit above 40H
	function automatic logic [3:0] hexVal(input logic [7:0] c);
		hexVal = c[6] ? 4'(c[3:0] + 4'h9) : c[3:0];
	endfunction

	// Value to ASCII hex digit
	function automatic logic [7:0] hexChr(input logic [3:0] n);
		hexChr = (n > 4'h9) ? 8'(CH_HEXOFS + {4'h0, n}) : {4'h3, n};
	endfunction

	function automatic logic isDigit(input logic [7:0] c);
		isDigit = (c[7:4] == 4'h3) && (c[3:0] <= 4'h9);
	endfunction

	// Byte-lane write merge
	function automatic logic [31:0] wrMask(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] s);
		wrMask = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				wrMask[i*8 +: 8] = d[i*8 +: 8];
			end
		end
	endfunction

	function automatic scl_cmd_e decode(input logic [23:0] c);
		case (c)
			CODE_PT_RD:    decode = CMD_PT_RD;
			CODE_BYTE_RD:  decode = CMD_BYTE_RD;
			CODE_PT_WR:    decode = CMD_PT_WR;
			CODE_BYTE_WR:  decode = CMD_BYTE_WR;
			CODE_PRG_RD:   decode = CMD_PRG_RD;
			CODE_PRG_WR:   decode = CMD_PRG_WR;
			CODE_WORD_RD:  decode = CMD_WORD_RD;
			CODE_WORD_WR:  decode = CMD_WORD_WR;
			CODE_HALT:     decode = CMD_HALT;
			CODE_RELEASE:  decode = CMD_RELEASE;
			CODE_RESTART:  decode = CMD_RESTART;
			CODE_DMY_HALT: decode = CMD_DMY_HALT;
			CODE_DMY_REL:  decode = CMD_DMY_REL;
			CODE_PRG_FILL: decode = CMD_PRG_FILL;
			default:       decode = CMD_NONE;
		endcase
	endfunction

	// Interval code to count of 10 ms steps
	function automatic logic [5:0] dlySteps(input logic [3:0] c);
		dlySteps = (c <= 4'h9) ? {2'h0, c} :
			6'(({2'h0, c} - 6'h09) * DLY_MULT);
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rstPipe_ff <= 2'h0;
		end else begin
			rstPipe_ff <= {rstPipe_ff[0], 1'b1};
		end
	end
	assign rstInt_b = rstPipe_ff[1];

	// Next-state logic for the whole block
	always_comb begin
		logic [9:0]  sh;
		logic [7:0]  ch;
		logic        chV;
		logic        chErr;
		logic        data7;
		logic        busy;
		logic        legacy;
		logic        skip;
		logic [7:0]  chk;
		logic [7:0]  tc;
		logic [4:0]  eCode;
		logic        eReq;
		logic [1:0]  effPrg;
		scl_cmd_e    dc;
		sh = '0;
		ch = '0;
		chV = 1'b0;
		chErr = 1'b0;
		chk = '0;
		tc = '0;
		eCode = '0;
		eReq = 1'b0;
		effPrg = '0;
		dc = CMD_NONE;
		nxt_st = st_ff;
		data7 = st_ff.ctrl[CTRL_DATA7];
		legacy = st_ff.ctrl[CTRL_LEGACY];
		skip = (st_ff.sc1 == CH_AT) && (st_ff.sc0 == CH_AT);
		busy = st_ff.pend | st_ff.waitDly | st_ff.dlyDone | st_ff.go |
			(st_ff.tSt != T_IDLE);
		nxt_st.snSel = !st_ff.ctrl[CTRL_ASSIGNED] && !legacy;

		// Wishbone slave, one wait state, unmapped reads give zero
		nxt_st.wbAck = 1'b0;
		if (cyc_i && stb_i && !st_ff.wbAck) begin
			nxt_st.wbAck = 1'b1;
			nxt_st.wbDat = 32'h0;
			if (adr_i[7:6] == BUF_WIN) begin
				// Compared at five bits so a full 16-entry buffer fits
				if ({1'b0, adr_i[5:2]} < 5'(DEPTH)) begin
					if (we_i && sel_i[0]) begin
						nxt_st.buff[BW'(adr_i[5:2])] = dat_i[7:0];
					end
					nxt_st.wbDat[7:0] = st_ff.buff[BW'(adr_i[5:2])];
				end
			end else if (we_i) begin
				case (adr_i)
					REG_CTRL: nxt_st.ctrl =
						12'(wrMask({20'h0, st_ff.ctrl}, dat_i, sel_i));
					REG_BAUD: nxt_st.baud =
						16'(wrMask({16'h0, st_ff.baud}, dat_i, sel_i));
					REG_RESP: begin
						if (st_ff.pend) begin
							nxt_st.pend = 1'b0;
							if (dat_i[RESP_ERR]) begin
								eReq = 1'b1;
								eCode = dat_i[RESP_CODE +: 5];
							end else begin
								nxt_st.tLen = (dat_i[7:0] > 8'(DEPTH)) ?
									8'(DEPTH) : dat_i[7:0];
								nxt_st.go = 1'b1;
							end
						end
					end
					default: ;
				endcase
			end else begin
				case (adr_i)
					REG_CTRL: nxt_st.wbDat = {20'h0, st_ff.ctrl};
					REG_BAUD: nxt_st.wbDat = {16'h0, st_ff.baud};
					REG_STAT: nxt_st.wbDat = {27'h0, st_ff.parErr,
						st_ff.snSel, st_ff.tSt != T_IDLE,
						st_ff.waitDly | st_ff.dlyDone, st_ff.pend};
					REG_CMD: nxt_st.wbDat = {4'h0, st_ff.riCode,
						st_ff.len, 7'h0, st_ff.selPres, st_ff.unit,
						st_ff.prog, st_ff.cmd};
					default: nxt_st.wbDat = 32'h0;
				endcase
			end
		end

		// Character receiver, samples at mid-bit
		sh = {rxd, st_ff.rxSh[9:1]};
		case (st_ff.rxSt)
			RX_IDLE: begin
				if (!rxd && !st_ff.txEn) begin
					nxt_st.rxSt = RX_START;
					nxt_st.rxCnt = st_ff.baud >> 1;
				end
			end
			RX_START: begin
				if (st_ff.rxCnt == 16'h0) begin
					nxt_st.rxSt = rxd ? RX_IDLE : RX_BITS;
					nxt_st.rxCnt = st_ff.baud - 16'h1;
					nxt_st.rxBit = 4'h0;
				end else begin
					nxt_st.rxCnt = st_ff.rxCnt - 16'h1;
				end
			end
			RX_BITS: begin
				if (st_ff.rxCnt == 16'h0) begin
					nxt_st.rxSh = sh;
					nxt_st.rxCnt = st_ff.baud - 16'h1;
					nxt_st.rxBit = st_ff.rxBit + 4'h1;
					if (st_ff.rxBit == (data7 ? 4'h8 : 4'h9)) begin
						nxt_st.rxSt = RX_IDLE;
						chV = 1'b1;
					end
				end else begin
					nxt_st.rxCnt = st_ff.rxCnt - 16'h1;
				end
			end
			default: nxt_st.rxSt = RX_IDLE;
		endcase
		ch = data7 ? {1'b0, sh[7:1]} : sh[7:0];
		chErr = (sh[8] != ^ch) || !sh[9];
		// Frames are taken only while no response is owed
		chV = chV && !busy && !st_ff.snSel;

		// Frame parser
		if (chV) begin
			if (ch == CH_COLON) begin
				nxt_st.pSt = P_ADH;
				nxt_st.sum = 8'h0;
				nxt_st.cnt = 8'h0;
				nxt_st.parErr = chErr;
				nxt_st.selPres = 1'b0;
			end else if (st_ff.pSt != P_IDLE) begin
				nxt_st.parErr = st_ff.parErr | chErr;
				nxt_st.sum = st_ff.sum + ch;
				case (st_ff.pSt)
					P_ADH: begin
						nxt_st.sc1 = ch;
						nxt_st.pSt = P_ADL;
					end
					P_ADL: begin
						// Octal digits 0-3 and 0-7 give 00 to 37
						if (st_ff.sc1[7:2] == 6'h0c && ch[7:3] == 5'h06 &&
							{st_ff.sc1[1:0], ch[2:0]} ==
							st_ff.ctrl[CTRL_STN +: 5]) begin
							nxt_st.pSt = P_RI;
						end else begin
							nxt_st.pSt = P_IDLE;
						end
					end
					P_RI: begin
						nxt_st.riCode = hexVal(ch);
						nxt_st.pSt = P_SEL;
					end
					P_SEL: begin
						// A digit here is a selector, a letter starts the
						// command name
						if (isDigit(ch)) begin
							nxt_st.selPres = 1'b1;
							nxt_st.selVal = ch[3:0];
							nxt_st.pSt = P_C1;
						end else begin
							nxt_st.code = {16'h0, ch};
							nxt_st.pSt = P_C2;
						end
					end
					P_C1: begin
						nxt_st.code = {16'h0, ch};
						nxt_st.pSt = P_C2;
					end
					P_C2: begin
						nxt_st.code = {st_ff.code[15:0], ch};
						nxt_st.pSt = (st_ff.code[15:8] == 8'h0) ?
							P_C2 : P_DATA;
					end
					P_DATA: begin
						if (ch == CH_CR) begin
							nxt_st.sum = st_ff.sum;
							nxt_st.pSt = P_IDLE;
							dc = decode(st_ff.code);
							effPrg = st_ff.selPres ? st_ff.selVal[1:0] :
								(dc == CMD_HALT || dc == CMD_RELEASE ||
								dc == CMD_RESTART) ? 2'h0 :
								st_ff.ctrl[CTRL_PPRG +: 2];
							chk = 8'(st_ff.sum - st_ff.sc1 - st_ff.sc0 +
								{hexVal(st_ff.sc1), hexVal(st_ff.sc0)});
							eReq = 1'b1;
							if (st_ff.parErr || chErr) begin
								eCode = ERR_PARITY;
							end else if (st_ff.cnt < 8'h2 ||
								(!skip && chk != 8'h0)) begin
								eCode = ERR_SUM;
							end else if (st_ff.cnt > 8'(DEPTH + 2)) begin
								eCode = ERR_OVF;
							end else if (dc == CMD_NONE) begin
								eCode = ERR_CMD;
							end else if ((dc == CMD_DMY_HALT ||
								dc == CMD_DMY_REL) && !legacy) begin
								eCode = ERR_MODE;
							end else if (!st_ff.selPres && !legacy &&
								(dc == CMD_PRG_RD || dc == CMD_PRG_WR ||
								dc == CMD_PRG_FILL)) begin
								eCode = ERR_SEL;
							end else if ((st_ff.selPres &&
								st_ff.selVal > 4'h3) || (effPrg == 2'h0 &&
								(dc == CMD_PRG_RD || dc == CMD_PRG_WR ||
								dc == CMD_PRG_FILL))) begin
								eCode = ERR_PRG;
							end else begin
								eReq = 1'b0;
								nxt_st.pend = 1'b1;
							end
							nxt_st.cmd = dc;
							nxt_st.prog = effPrg;
							nxt_st.len = 8'(st_ff.cnt - 8'h2);
							nxt_st.unit = (dc == CMD_WORD_RD ||
								dc == CMD_WORD_WR) ? UNIT_WORD :
								(dc == CMD_BYTE_RD || dc == CMD_BYTE_WR) ?
								UNIT_BYTE : UNIT_BIT;
							nxt_st.waitDly = 1'b1;
							nxt_st.steps = dlySteps(st_ff.riCode);
							nxt_st.cyc = 32'h0;
						end else begin
							if (st_ff.cnt < 8'(DEPTH)) begin
								nxt_st.buff[BW'(st_ff.cnt)] = ch;
							end
							if (st_ff.cnt != 8'hff) begin
								nxt_st.cnt = st_ff.cnt + 8'h1;
							end
							nxt_st.sc1 = st_ff.sc0;
							nxt_st.sc0 = ch;
						end
					end
					default: nxt_st.pSt = P_IDLE;
				endcase
			end
		end

		// Error answer: marker then two hex digits of the code
		if (eReq) begin
			nxt_st.buff[0] = CH_ERR;
			nxt_st.buff[1] = hexChr({3'h0, eCode[4]});
			nxt_st.buff[2] = hexChr(eCode[3:0]);
			nxt_st.tLen = 8'h03;
			nxt_st.go = 1'b1;
		end

		// Response delay timer counted in 10 ms steps
		if (st_ff.waitDly) begin
			if (st_ff.steps == 6'h0) begin
				nxt_st.waitDly = 1'b0;
				nxt_st.dlyDone = 1'b1;
			end else if (st_ff.cyc == 32'(STEP_CYC - 1)) begin
				nxt_st.cyc = 32'h0;
				nxt_st.steps = st_ff.steps - 6'h1;
			end else begin
				nxt_st.cyc = st_ff.cyc + 32'h1;
			end
		end

		// Response transmitter
		case (st_ff.tIdx)
			8'h0: tc = CH_COLON;
			8'h1: tc = {6'h0c, st_ff.ctrl[CTRL_STN+3 +: 2]};
			8'h2: tc = {5'h06, st_ff.ctrl[CTRL_STN +: 3]};
			default: begin
				if (st_ff.tIdx < 8'(st_ff.tLen + 8'h3)) begin
					tc = st_ff.buff[BW'(st_ff.tIdx - 8'h3)];
				end else if (st_ff.tIdx == 8'(st_ff.tLen + 8'h3)) begin
					tc = hexChr(4'((8'h0 - st_ff.tSum) >> 4));
				end else if (st_ff.tIdx == 8'(st_ff.tLen + 8'h4)) begin
					tc = hexChr(4'(8'h0 - st_ff.tSum));
				end else begin
					tc = CH_CR;
				end
			end
		endcase
		case (st_ff.tSt)
			T_IDLE: begin
				if (st_ff.dlyDone && st_ff.go) begin
					nxt_st.tSt = T_LOAD;
					nxt_st.tIdx = 8'h0;
					nxt_st.tSum = 8'h0;
					nxt_st.dlyDone = 1'b0;
					nxt_st.go = 1'b0;
					nxt_st.txEn = 1'b1;
				end
			end
			T_LOAD: begin
				if (st_ff.tIdx != 8'h0 &&
					st_ff.tIdx < 8'(st_ff.tLen + 8'h3)) begin
					nxt_st.tSum = st_ff.tSum + tc;
				end
				nxt_st.tSh = data7 ? {3'h7, ^tc[6:0], tc[6:0]} :
					{2'h3, ^tc, tc};
				nxt_st.txd = 1'b0;
				nxt_st.tBit = 4'h0;
				nxt_st.tCnt = st_ff.baud - 16'h1;
				nxt_st.tSt = T_SHIFT;
			end
			T_SHIFT: begin
				if (st_ff.tCnt != 16'h0) begin
					nxt_st.tCnt = st_ff.tCnt - 16'h1;
				// Data, parity and every stop bit are shifted before idle
				end else if (st_ff.tBit == 4'(4'ha - {3'h0, data7} +
					{3'h0, st_ff.ctrl[CTRL_STOP2]})) begin
					nxt_st.txd = 1'b1;
					if (st_ff.tIdx == 8'(st_ff.tLen + 8'h5)) begin
						nxt_st.tSt = T_IDLE;
						nxt_st.txEn = 1'b0;
					end else begin
						nxt_st.tIdx = st_ff.tIdx + 8'h1;
						nxt_st.tSt = T_LOAD;
					end
				end else begin
					nxt_st.txd = st_ff.tSh[0];
					nxt_st.tSh = {1'b1, st_ff.tSh[10:1]};
					nxt_st.tBit = st_ff.tBit + 4'h1;
					nxt_st.tCnt = st_ff.baud - 16'h1;
				end
			end
			default: nxt_st.tSt = T_IDLE;
		endcase
	end

	// State register; clock enable low freezes it, but the reset release flops still run
	always_ff @(posedge clk_sys or negedge rstInt_b) begin
		if (!rstInt_b) begin
			st_ff <= ST_RST;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign dat_o = st_ff.wbDat;
	assign ack_o = st_ff.wbAck;
	assign txd   = st_ff.txd;
	assign txEn  = st_ff.txEn;
	assign snSel = st_ff.snSel;
endmodule

// ---- hw/scl_pkg.sv ----
/*
 Shared constants for the serial computer link slave: register map,
 field positions, reset values, characters, error codes and timing.
 Assumes a 250 MHz system clock and a 32-bit classic Wishbone host.
*/
package scl_pkg;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_BAUD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_CMD  = 8'h0c;
	localparam logic [7:0] REG_RESP = 8'h10;
	localparam logic [1:0] BUF_WIN  = 2'h1; // Window 0x40..0x7c
	// Control fields
	localparam int CTRL_STN   = 0;  // 5-bit station number
	localparam int CTRL_DATA7 = 5;
	localparam int CTRL_STOP2 = 6;
	localparam int CTRL_LEGACY = 7;
	localparam int CTRL_ASSIGNED = 8;
	localparam int CTRL_PPRG  = 9;  // 2-bit parameter program
	localparam logic [11:0] CTRL_RST = 12'h100;
	// 38.4 kbps at 250 MHz
	localparam logic [15:0] BAUD_RST = 16'h196e;
	// Response control fields
	localparam int RESP_CODE = 8;
	localparam int RESP_ERR  = 13;
	// Characters
	localparam logic [7:0] CH_COLON = 8'h3a;
	localparam logic [7:0] CH_CR    = 8'h0d;
	localparam logic [7:0] CH_AT    = 8'h40;
	localparam logic [7:0] CH_ERR   = 8'h21;
	localparam logic [7:0] CH_HEXOFS = 8'h37;
	// Error codes
	localparam logic [4:0] ERR_PARITY = 5'h01;
	localparam logic [4:0] ERR_SUM    = 5'h02;
	localparam logic [4:0] ERR_OVF    = 5'h03;
	localparam logic [4:0] ERR_CMD    = 5'h04;
	localparam logic [4:0] ERR_MODE   = 5'h05;
	localparam logic [4:0] ERR_SEL    = 5'h06;
	localparam logic [4:0] ERR_PRG    = 5'h07;
	// Response delay: 10 ms steps, codes A..F in 100 ms steps
	localparam int DLY_STEP_MS = 10;
	localparam int CLK_KHZ     = 250000;
	localparam int STEP_CYC_DEF = DLY_STEP_MS * CLK_KHZ;
	localparam logic [5:0] DLY_MULT = 6'h0a;
	// Transfer units
	localparam logic [1:0] UNIT_BIT  = 2'h0;
	localparam logic [1:0] UNIT_BYTE = 2'h1;
	localparam logic [1:0] UNIT_WORD = 2'h2;
	// Command letter codes
	localparam logic [23:0] CODE_PT_RD   = 24'h4d524c;
	localparam logic [23:0] CODE_BYTE_RD = 24'h4d5242;
	localparam logic [23:0] CODE_PT_WR   = 24'h535252;
	localparam logic [23:0] CODE_BYTE_WR = 24'h535242;
	localparam logic [23:0] CODE_PRG_RD  = 24'h52504d;
	localparam logic [23:0] CODE_PRG_WR  = 24'h57504d;
	localparam logic [23:0] CODE_WORD_RD = 24'h524452;
	localparam logic [23:0] CODE_WORD_WR = 24'h574452;
	localparam logic [23:0] CODE_HALT    = 24'h484c54;
	localparam logic [23:0] CODE_RELEASE = 24'h52554e;
	localparam logic [23:0] CODE_RESTART = 24'h535441;
	localparam logic [23:0] CODE_DMY_HALT = 24'h505343;
	localparam logic [23:0] CODE_DMY_REL = 24'h505243;
	localparam logic [23:0] CODE_PRG_FILL = 24'h46494c;
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0, CMD_PT_RD = 4'h1, CMD_BYTE_RD = 4'h2,
		CMD_PT_WR = 4'h3, CMD_BYTE_WR = 4'h4, CMD_PRG_RD = 4'h5,
		CMD_PRG_WR = 4'h6, CMD_WORD_RD = 4'h7, CMD_WORD_WR = 4'h8,
		CMD_HALT = 4'h9, CMD_RELEASE = 4'ha, CMD_RESTART = 4'hb,
		CMD_DMY_HALT = 4'hc, CMD_DMY_REL = 4'hd, CMD_PRG_FILL = 4'he
	} scl_cmd_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10
	} scl_rx_e;
	typedef enum logic [2:0] {
		P_IDLE = 3'b000, P_ADH = 3'b001, P_ADL = 3'b010, P_RI = 3'b011,
		P_SEL = 3'b100, P_C1 = 3'b101, P_C2 = 3'b110, P_DATA = 3'b111
	} scl_prs_e;
	typedef enum logic [1:0] {
		T_IDLE = 2'b00, T_LOAD = 2'b01, T_SHIFT = 2'b10
	} scl_tx_e;
endpackage

// ---- test/scl_link_chk.sv ----
/*
 Port checks for the link slave: bus answer timing and line framing.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/100ps
module scl_link_chk (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        ce,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        rxd,
	input wire logic        txd,
	input wire logic        txEn,
	input wire logic        snSel
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// A response frame opens with its first start bit
	sequence s_open;
		$rose(txEn);
	endsequence
	sequence s_start;
		##[0:2] !txd;
	endsequence
	ack_one_a: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	ack_next_a: assert property (cyc_i && stb_i && !ack_o && ce |=> ack_o)
		else $error("request not answered");
	ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
		else $error("ack without request");
	line_idle_a: assert property (!txEn |-> txd)
		else $error("line not idle high");
	start_bit_a: assert property (s_open |-> s_start)
		else $error("no start bit");
	frame_hold_a: assert property (s_open |=> txEn [*8])
		else $error("enable dropped early");
	stop_bit_a: assert property ($fell(txEn) |-> $past(txd))
		else $error("frame not closed at stop level");
	sensor_quiet_a: assert property (snSel |-> !txEn)
		else $error("transmit in sensor mode");
	unmapped_read_a: assert property (ack_o && $past(adr_i) == 8'h20
		&& !$past(we_i) |-> dat_o == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind scl_link_slave scl_link_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
	.ce(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.rxd(rxd), .txd(txd), .txEn(txEn), .snSel(snSel));

// ---- test/scl_host_model.sv ----
/*
 Host end of the serial link: sends characters on rxd, takes them
 from txd. Assumes 8 data bits, even parity, one stop bit.
*/
`timescale 1ns/100ps
module scl_host_model #(
	parameter int BIT_CYC = 8
)(
	input  wire logic clk_sys,
	input  wire logic txd,
	output logic      rxd
);
	initial rxd = 1'b1; // Line rests at mark level
	// One character LSB first; parity can be spoiled on purpose
	task automatic send_char(input logic [7:0] c, input logic badPar);
		logic [10:0] fr;
		fr = {1'b1, ^c ^ badPar, c, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= fr[i];
			repeat (BIT_CYC) @(posedge clk_sys);
		end
	endtask
	// Host only listens while a response is owed, never talks over it
	task automatic get_char(output logic [7:0] c, output logic ok);
		logic [9:0] sh;
		int         n;
		c = 8'hff;
		ok = 1'b0;
		for (n = 0; n < 4000 && txd !== 1'b0; n++)
			@(posedge clk_sys);
		if (txd !== 1'b0)
			return;
		repeat (BIT_CYC / 2) @(posedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			repeat (BIT_CYC) @(posedge clk_sys);
			sh[i] = txd;
		end
		c = sh[7:0];
		ok = !(^sh[8:0]) && sh[9];
	endtask
endmodule

// ---- test/tb_top.sv ----
/*
 Bench for the link slave: registers over classic Wishbone, command
 frames from the host model, response frames checked char by char.
 Assumes the checker binds itself.
*/
`timescale 1ns/100ps
module tb_top
	import scl_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic        ce = 1'b1;
	logic        cycI = 1'b0;
	logic        stbI = 1'b0;
	logic        weI = 1'b0;
	logic [7:0]  adrI = 8'h00;
	logic [31:0] datI = 32'h0;
	logic [31:0] datO;
	logic [31:0] rd;
	logic        ackO;
	logic        rxd;
	logic        txd;
	logic        txEn;
	logic        snSel;
	int          nErrors = 0;
	int          numChecks = 0;
	always #2 clk_sys = ~clk_sys;
	// Short delay step keeps the longest interval code (F, 60 steps) at 1200 clocks
	scl_link_slave #(.DEPTH(16), .STEP_CYC(20)) dut (.clk_sys(clk_sys),
		.rst_b(rst_b), .ce(ce), .cyc_i(cycI), .stb_i(stbI), .we_i(weI),
		.adr_i(adrI), .sel_i(4'hf), .dat_i(datI), .dat_o(datO),
		.ack_o(ackO), .rxd(rxd), .txd(txd), .txEn(txEn), .snSel(snSel));
	scl_host_model #(.BIT_CYC(8)) host (.clk_sys(clk_sys), .txd(txd),
		.rxd(rxd));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Classic single cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		cycI <= 1'b1;
		stbI <= 1'b1;
		weI <= w;
		adrI <= a;
		datI <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (ackO === 1'b1)
				break;
		end
		rd = datO;
		cycI <= 1'b0;
		stbI <= 1'b0;
		if (i == 20) begin
			nErrors++;
			tally_and_finish();
		end
	endtask
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	// Mode 1 spoils the sum, 2 sends two at-signs, 3 bad parity
	task automatic frame(input string b, input int mode);
		logic [7:0] s;
		s = 8'h00;
		@(posedge clk_sys);
		host.send_char(CH_COLON, 1'b0);
		for (int i = 0; i < b.len(); i++) begin
			host.send_char(b[i], 1'(mode == 3 && i == b.len() - 1));
			s += b[i];
		end
		s = 8'h00 - s + 8'(mode == 1);
		host.send_char(mode == 2 ? CH_AT : hx(s[7:4]), 1'b0);
		host.send_char(mode == 2 ? CH_AT : hx(s[3:0]), 1'b0);
		host.send_char(CH_CR, 1'b0);
	endtask
	// Response from station 05 with payload p, start after about dly
	task automatic resp(input string p, input int dly);
		logic [7:0] s;
		logic [7:0] c;
		logic       ok;
		int         n;
		s = 8'h00;
		for (n = 0; n < 4000 && txEn !== 1'b1; n++)
			@(posedge clk_sys);
		if (n == 4000) begin
			nErrors++;
			tally_and_finish();
		end
		check(32'(n + 8 >= dly && n <= dly + 8), 32'h1);
		p = {"05", p};
		host.get_char(c, ok);
		check(32'({ok, c}), {23'h0, 1'b1, CH_COLON});
		for (int i = 0; i < p.len(); i++) begin
			host.get_char(c, ok);
			check(32'({ok, c}), {23'h0, 1'b1, p[i]});
			s += p[i];
		end
		s = 8'h00 - s;
		host.get_char(c, ok);
		check(32'(c), 32'(hx(s[7:4])));
		host.get_char(c, ok);
		check(32'(c), 32'(hx(s[3:0])));
		host.get_char(c, ok);
		check(32'(c), 32'(CH_CR));
		repeat (16) @(posedge clk_sys);
	endtask
	task automatic regs();
		wb(1'b0, REG_CTRL, 32'h0);
		check(rd, 32'(CTRL_RST));
		wb(1'b0, REG_BAUD, 32'h0);
		check(rd, 32'(BAUD_RST));
		wb(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0);
		wb(1'b1, REG_CTRL, 32'h0);
		wb(1'b0, REG_STAT, 32'h0);
		check(32'({snSel, rd[3]}), 32'h3);
		wb(1'b1, REG_CTRL, 32'h80);
		wb(1'b0, REG_STAT, 32'h0);
		check(32'({snSel, rd[3]}), 32'h0);
		wb(1'b1, REG_BAUD, 32'h8);
		wb(1'b1, REG_CTRL, 32'h105);
	endtask
	// Faulty or refused commands answered with an error code, then a frame for station 06 that gets no answer
	task automatic errs();
		string b[6] = '{"051XYZ", "05APSC", "050RPM", "0500RPM",
			"050HLT", "050HLT"};
		string p[6] = '{"!04", "!05", "!06", "!07", "!02", "!01"};
		int    m[6] = '{0, 0, 0, 0, 1, 3};
		int    d[6] = '{20, 200, 0, 0, 0, 0};
		int    n;
		for (int i = 0; i < 6; i++) begin
			frame(b[i], m[i]);
			resp(p[i], d[i]);
		end
		frame("060HLT", 0);
		for (n = 0; n < 300 && txEn !== 1'b1; n++)
			@(posedge clk_sys);
		check(32'(n), 32'h12c);
	endtask
	task automatic cmds();
		frame("050HLT", 2);
		wb(1'b0, REG_CMD, 32'h0);
		check(rd & 32'h0f00_013f, 32'h0000_0009);
		wb(1'b1, REG_RESP, 32'h0);
		resp("", 0);
		frame("0502RDRX0010", 0);
		wb(1'b0, REG_CMD, 32'h0);
		check(rd & 32'h0fff_01ff, 32'h0005_01a7);
		wb(1'b0, 8'h40, 32'h0);
		check(rd & 32'hff, 32'h58);
		wb(1'b1, REG_RESP, 32'h0);
		resp("", 0);
		// Legacy mode, two stop bits, parameter program 2
		wb(1'b1, REG_CTRL, 32'h5c5);
		frame("050PSC", 0);
		wb(1'b0, REG_CMD, 32'h0);
		check(rd & 32'h0f00_013f, 32'h0000_002c);
		wb(1'b1, REG_RESP, 32'h0);
		resp("", 0);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		regs();
		errs();
		cmds();
		tally_and_finish();
	end
endmodule
